// [lads_link_fsm.v]
// Link access state machine with duplicate node address detection.
// Assumes a CAN controller on core_clk_in giving one-cycle event pulses.
`timescale 1ns/1ps
`include "lads_defs.vh"

// Function
// - Four states: sending check, waiting check, on-line, communication fault.
// - Check request sent while sending: start 1 s timer, go waiting.
// - First timer expiry while waiting: resend check request, back to sending.
// - Second consecutive timer expiry while waiting: go on-line.
// - Bus-off in sending, waiting, or on-line with hold: reset transceiver, fault.
// - Bus-off on-line with auto recovery: reset, request check, go sending.
// - Own-address check request: fault if checking, send response if on-line.
// - Non-check messages discarded unless on-line, where they are passed on.
// - Error passive or warning during check transmit is ignored.
// - Check messages with own address in group 2 field are processed, except in fault.
module lads_link_fsm #(
    parameter [`LADS_TMR_W-1:0] CHECK_CYCLES = `LADS_CHECK_CYCLES
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Configuration pins
    input wire [`LADS_ADDR_W-1:0] node_address_in,
    input wire bus_off_recovery_choice_in,
    // CAN controller events
    input wire tx_check_done_in,
    input wire bus_off_in,
    input wire error_passive_in,
    input wire error_warning_in,
    input wire rx_valid_in,
    input wire [10:0] rx_id_in,
    input wire rx_is_response_in,
    // Internal transmit request
    input wire int_tx_req_in,
    // Controls to CAN controller and transceiver
    output wire send_check_req_out,
    output wire send_check_resp_out,
    output wire ctrl_reset_out,
    output wire xcvr_hold_reset_out,
    // Requester and upper layer
    output wire int_tx_go_out,
    output wire int_tx_err_out,
    output wire rx_deliver_out,
    output wire dup_detected_out,
    output wire [1:0] state_out
);

    localparam [1:0] ST_SEND = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_ONLINE = 2'h2;
    localparam [1:0] ST_FAULT = 2'h3;

    ////////////////////////////////////////////////////////////////////////

    // Both pins cross into this clock domain
    reg [`LADS_ADDR_W-1:0] addr_s1_q;
    reg [`LADS_ADDR_W-1:0] addr_q;
    reg boi_s1_q;
    reg boi_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`LADS_TMR_W-1:0] tmr_q;
    reg [`LADS_TMR_W-1:0] tmr_d;
    reg second_q;
    reg second_d;
    reg send_req_q;
    reg send_req_d;
    reg send_resp_q;
    reg send_resp_d;
    reg ctrl_rst_q;
    reg ctrl_rst_d;
    reg hold_q;
    reg hold_d;
    reg go_q;
    reg go_d;
    reg err_q;
    reg err_d;
    reg deliver_q;
    reg deliver_d;
    reg dup_q;
    reg dup_d;

    // Group 2 check message, whatever its address field
    function lads_is_check;
        input [10:0] id;
        begin
            lads_is_check = (id[10:9] == `LADS_GRP2_TAG) && (id[2:0] == `LADS_CHECK_MSG_ID);
        end
    endfunction

    // Group 2 check message addressed to this node
    wire rx_check = rx_valid_in && lads_is_check(rx_id_in)
        && (rx_id_in[8:3] == addr_q);
    wire rx_other = rx_valid_in && !lads_is_check(rx_id_in);
    wire tmr_expire = (state_q == ST_WAIT) && (tmr_q == {`LADS_TMR_W{1'b0}});
    // Error passive and warning take no part in any decision
    wire unused_err = error_passive_in | error_warning_in;

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_s1_q <= {`LADS_ADDR_W{1'b0}};
            addr_q <= {`LADS_ADDR_W{1'b0}};
            boi_s1_q <= 1'b0;
            boi_q <= 1'b0;
        end else begin
            addr_s1_q <= node_address_in;
            addr_q <= addr_s1_q;
            boi_s1_q <= bus_off_recovery_choice_in;
            boi_q <= boi_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always @* begin
        state_d = state_q;
        tmr_d = tmr_q;
        second_d = second_q;
        send_req_d = 1'b0;
        send_resp_d = 1'b0;
        ctrl_rst_d = 1'b0;
        hold_d = hold_q;
        go_d = 1'b0;
        err_d = 1'b0;
        deliver_d = 1'b0;
        dup_d = 1'b0;
        if (state_q == ST_WAIT && tmr_q != {`LADS_TMR_W{1'b0}}) begin
            tmr_d = tmr_q - 1'b1;
        end
        // Internal transmit gating
        if (int_tx_req_in) begin
            if (state_q == ST_ONLINE) begin
                go_d = 1'b1;
            end else begin
                err_d = 1'b1;
            end
        end
        // Non-check traffic
        if (rx_other && state_q == ST_ONLINE) begin
            deliver_d = 1'b1;
        end
        case (state_q)
            ST_SEND: begin
                if (bus_off_in) begin
                    hold_d = 1'b1;
                    state_d = ST_FAULT;
                end else if (rx_check) begin
                    dup_d = 1'b1;
                    state_d = ST_FAULT;
                end else if (tx_check_done_in) begin
                    tmr_d = CHECK_CYCLES - 1'b1;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (bus_off_in) begin
                    hold_d = 1'b1;
                    state_d = ST_FAULT;
                end else if (rx_check) begin
                    dup_d = 1'b1;
                    state_d = ST_FAULT;
                end else if (tmr_expire) begin
                    if (second_q) begin
                        state_d = ST_ONLINE;
                    end else begin
                        second_d = 1'b1;
                        send_req_d = 1'b1;
                        state_d = ST_SEND;
                    end
                end
            end
            ST_ONLINE: begin
                if (bus_off_in) begin
                    if (boi_q) begin
                        ctrl_rst_d = 1'b1;
                        send_req_d = 1'b1;
                        second_d = 1'b0;
                        state_d = ST_SEND;
                    end else begin
                        hold_d = 1'b1;
                        state_d = ST_FAULT;
                    end
                end else if (rx_check && rx_is_response_in) begin
                    dup_d = 1'b1;
                    state_d = ST_FAULT;
                end else if (rx_check) begin
                    send_resp_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_FAULT;
            end
        endcase
    end

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_SEND;
            tmr_q <= {`LADS_TMR_W{1'b0}};
            second_q <= 1'b0;
            send_req_q <= 1'b0;
            send_resp_q <= 1'b0;
            ctrl_rst_q <= 1'b0;
            hold_q <= 1'b0;
            go_q <= 1'b0;
            err_q <= 1'b0;
            deliver_q <= 1'b0;
            dup_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            second_q <= second_d;
            send_req_q <= send_req_d;
            send_resp_q <= send_resp_d;
            ctrl_rst_q <= ctrl_rst_d;
            hold_q <= hold_d;
            go_q <= go_d;
            err_q <= err_d;
            deliver_q <= deliver_d;
            dup_q <= dup_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign send_check_req_out = send_req_q;
    assign send_check_resp_out = send_resp_q;
    assign ctrl_reset_out = ctrl_rst_q;
    assign xcvr_hold_reset_out = hold_q;
    assign int_tx_go_out = go_q;
    assign int_tx_err_out = err_q;
    assign rx_deliver_out = deliver_q;
    assign dup_detected_out = dup_q;
    assign state_out = state_q;

endmodule // lads_link_fsm

// [lads_defs.vh]
// Constants for the link access and duplicate address check state machine.
// Assumes a 100 MHz core clock.
`ifndef LADS_DEFS_VH
`define LADS_DEFS_VH

`define LADS_CLK_MHZ 100
`define LADS_CHECK_TIME_MS 1000
// One second of core clock cycles, sized to the timer width
`define LADS_CHECK_CYCLES 27'h5F5E100
`define LADS_TMR_W 27
`define LADS_ADDR_W 6
`define LADS_CHECK_MSG_ID 3'h7
`define LADS_GRP2_TAG 2'h2

`endif

// [lads_peer_node.sv]
// Another node on the shared bus, sending frames to the node under test.
// Assumes commands arrive just after a core clock edge.
`timescale 1ns/1ps
module lads_peer_node (
    // Clock and command
    input wire core_clk_in,
    input wire send_in,
    input wire check_in,
    input wire resp_in,
    input wire [5:0] addr_in,
    // Frame to the node
    output reg rx_valid_out = 1'b0,
    output reg [10:0] rx_id_out = 11'h000,
    output reg rx_is_response_out = 1'b0
);
    // Between frames the id and kind lines toggle instead of holding
    always @(posedge core_clk_in) begin
        rx_valid_out <= send_in;
        rx_id_out <= send_in ? {2'h2, addr_in, check_in ? 3'h7 : 3'h5} : ~rx_id_out;
        rx_is_response_out <= send_in ? resp_in : ~rx_is_response_out;
    end
endmodule // lads_peer_node

// [lads_link_fsm_assertions.sv]
// Checker for the link access state machine, bound to its ports.
// Assumes one core clock and the asynchronous high reset.
`timescale 1ns/1ps
`include "lads_defs.vh"
module lads_link_fsm_assertions #(
    parameter [`LADS_TMR_W-1:0] CHECK_CYCLES = 27'h8
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Configuration pins
    input wire [`LADS_ADDR_W-1:0] node_address_in,
    input wire bus_off_recovery_choice_in,
    // Controller events, received frames and internal transmit request
    input wire tx_check_done_in,
    input wire bus_off_in,
    input wire rx_valid_in,
    input wire [10:0] rx_id_in,
    input wire rx_is_response_in,
    input wire int_tx_req_in,
    // Outputs of the state machine
    input wire send_check_req_out,
    input wire send_check_resp_out,
    input wire ctrl_reset_out,
    input wire xcvr_hold_reset_out,
    input wire int_tx_go_out,
    input wire int_tx_err_out,
    input wire rx_deliver_out,
    input wire dup_detected_out,
    input wire [1:0] state_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire own = rx_valid_in && rx_id_in[10:9] == 2'h2 && rx_id_in[2:0] == 3'h7
        && rx_id_in[8:3] == node_address_in;
    reg [`LADS_TMR_W-1:0] wait_q;
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) wait_q <= 27'h0;
        else wait_q <= (state_out == 2'h1) ? wait_q + 27'h1 : 27'h0;
    end
    property p_done; state_out == 2'h0 && tx_check_done_in && !bus_off_in && !own
        |=> state_out == 2'h1; endproperty
    a_done: assert property (p_done) else $error("no wait");
    property p_tmr; state_out == 2'h1 |-> wait_q < CHECK_CYCLES; endproperty
    a_tmr: assert property (p_tmr) else $error("wait long");
    property p_exp; $fell(state_out == 2'h1) && !$past(bus_off_in) && !$past(own)
        |-> wait_q == CHECK_CYCLES && (state_out == 2'h2 || send_check_req_out
        && state_out == 2'h0); endproperty
    a_exp: assert property (p_exp) else $error("bad expiry");
    property p_boff; bus_off_in && (state_out < 2'h2 || state_out == 2'h2
        && !bus_off_recovery_choice_in) |=> state_out == 2'h3 && xcvr_hold_reset_out; endproperty
    a_boff: assert property (p_boff) else $error("bus off");
    property p_auto; bus_off_in && state_out == 2'h2 && bus_off_recovery_choice_in
        |=> state_out == 2'h0 && ctrl_reset_out && send_check_req_out; endproperty
    a_auto: assert property (p_auto) else $error("auto reset");
    property p_req; own && !rx_is_response_in && !bus_off_in
        |=> send_check_resp_out == ($past(state_out) == 2'h2); endproperty
    a_req: assert property (p_req) else $error("response");
    property p_dup; own && !bus_off_in && (state_out < 2'h2 || rx_is_response_in
        && state_out == 2'h2) |=> state_out == 2'h3 && dup_detected_out; endproperty
    a_dup: assert property (p_dup) else $error("duplicate");
    property p_flt; state_out == 2'h3 |=> state_out == 2'h3 && !send_check_req_out; endproperty
    a_flt: assert property (p_flt) else $error("left fault");
    property p_tx; int_tx_req_in |=> int_tx_go_out != int_tx_err_out
        && int_tx_go_out == ($past(state_out) == 2'h2); endproperty
    a_tx: assert property (p_tx) else $error("tx gate");
    property p_dlv; rx_deliver_out |-> $past(rx_valid_in) && $past(state_out) == 2'h2;
    endproperty
    a_dlv: assert property (p_dlv) else $error("deliver");
endmodule // lads_link_fsm_assertions
bind lads_link_fsm lads_link_fsm_assertions #(.CHECK_CYCLES(CHECK_CYCLES)) u_chk (.*);

// [lads_link_fsm_tb.sv]
// Self-checking bench for the link access state machine.
// Assumes a shortened check timer of eight cycles.
`timescale 1ns/1ps
module lads_link_fsm_tb;
    logic clk = 1'b0, rst = 1'b1, choice = 1'b0, done = 1'b0, boff = 1'b0, ep = 1'b0;
    logic treq = 1'b0, send = 1'b0, chkf = 1'b0, resp = 1'b0, rv, rr;
    logic [10:0] rid;
    wire req, rsp, crst, hold, go, terr, dlv, dup;
    wire [1:0] st;
    int err_count = 0, tests_run = 0;
    always #5 clk = ~clk;
    lads_peer_node peer (.core_clk_in(clk), .send_in(send), .check_in(chkf),
        .resp_in(resp), .addr_in(6'h2A), .rx_valid_out(rv), .rx_id_out(rid),
        .rx_is_response_out(rr));
    lads_link_fsm #(.CHECK_CYCLES(27'h8)) dut (.core_clk_in(clk), .rst_in(rst),
        .node_address_in(6'h2A), .bus_off_recovery_choice_in(choice),
        .tx_check_done_in(done), .bus_off_in(boff), .error_passive_in(ep),
        .error_warning_in(ep), .rx_valid_in(rv), .rx_id_in(rid), .rx_is_response_in(rr),
        .int_tx_req_in(treq), .send_check_req_out(req), .send_check_resp_out(rsp),
        .ctrl_reset_out(crst), .xcvr_hold_reset_out(hold), .int_tx_go_out(go),
        .int_tx_err_out(terr), .rx_deliver_out(dlv), .dup_detected_out(dup), .state_out(st));
    task finish_test;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    // 0 sent, 1 bus off, 2 tx request, 3 own request, 4 own response, 5 other frame
    task ev(input int k);
        case (k)
            0: done = 1'b1;
            1: boff = 1'b1;
            2: treq = 1'b1;
            default: {send, chkf, resp} = {1'b1, k < 5, k == 4};
        endcase
        tick;
        {done, boff, treq, send} = 4'h0;
        if (k > 2) tick;
    endtask
    task wst(input logic [1:0] s);
        for (int i = 0; i < 100 && st !== s; i++) tick;
        if (st !== s) begin
            err_count++;
            finish_test;
        end
    endtask
    task boot(input logic c);
        {rst, choice} = {1'b1, c};
        repeat (6) tick;
        rst = 1'b0;
        repeat (3) tick;
    endtask
    task online;
        ep = 1'b1;
        ev(0);
        chk(st, 2'h1);
        wst(2'h0);
        chk(req, 2'h1);
        ev(0);
        ep = 1'b0;
        wst(2'h2);
        chk(st, 2'h2);
    endtask
    task t_gate;
        boot(1'b0);
        ev(2);
        chk(terr, 2'h1);
        ev(5);
        chk(dlv, 2'h0);
        online;
        ev(2);
        chk(go, 2'h1);
        ev(5);
        chk(dlv, 2'h1);
    endtask
    task t_dup;
        ev(3);
        chk(rsp, 2'h1);
        ev(4);
        chk({dup, st[0]}, 2'h3);
        ev(3);
        chk({rsp, st}, 3'h3);
        boot(1'b0);
        ev(0);
        ev(3);
        chk({dup, st[0]}, 2'h3);
    endtask
    task t_boff;
        boot(1'b0);
        ev(1);
        chk({hold, st[0]}, 2'h3);
        boot(1'b1);
        online;
        ev(1);
        chk({crst, req}, 2'h3);
        chk(st, 2'h0);
        boot(1'b0);
        online;
        ev(1);
        chk(st, 2'h3);
    endtask
    initial begin
        t_gate;
        t_dup;
        t_boff;
        finish_test;
    end
endmodule // lads_link_fsm_tb
